// *** rom_pc_model.sv ***
// microprogram store and program counter standing beyond the decoder
module rom_pc_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pc_inc,
  input  wire logic       pc_load,
  input  wire logic [1:0] pc_page,
  output logic      [7:0] instr,
  output logic      [9:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [1024];

  // word at the counter is offered at once, so a fetch is never late
  assign instr = mem[pc];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= 10'h000;
    end else if (pc_load) begin
      pc <= {pc_page, instr};
    end else if (pc_inc) begin
      pc <= pc + 10'h001;
    end
  end
endmodule

// *** tb_top.sv ***
module tb_top
  import term_dec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pc_inc, pc_load, ram_we, uart_load, print_load, pixel;
  logic        printer_run, cursor_ff, video_ff;
  logic        we_q = 1'b0;
  logic [1:0]  pc_page;
  logic [7:0]  paddr, ram_rdata, uart_rx_char, instr, ram_wdata, uart_wdata;
  logic [7:0]  print_data, xpos, ypos, acc;
  logic [9:0]  pc;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] pix;
  logic [7:0]  wq[$], uq[$], pq[$];
  cond_s       cnd;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  logic [17:0] prog [31] = '{18'h0010C, 18'h00212, 18'h00328, 18'h0042A,
    18'h00574, 18'h00664, 18'h00744, 18'h00824, 18'h00952, 18'h00A32,
    18'h00B60, 18'h00C20, 18'h00D10, 18'h00E58, 18'h00F71, 18'h01020,
    18'h02041, 18'h02130, 18'h03001, 18'h03140, 18'h04054, 18'h04151,
    18'h04200, 18'h10078, 18'h10171, 18'h102FF, 18'h10350, 18'h10470,
    18'h10540, 18'h10651, 18'h10706};

  terminal_microcode_decoder u_terminal_microcode_decoder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr(instr),
    .ram_rdata(ram_rdata), .uart_rx_char(uart_rx_char), .cond_pins(cnd),
    .pc_inc(pc_inc), .pc_load(pc_load), .pc_page(pc_page),
    .ram_we(ram_we), .ram_wdata(ram_wdata), .uart_load(uart_load),
    .uart_wdata(uart_wdata), .print_load(print_load),
    .print_data(print_data), .printer_run(printer_run),
    .cursor_ff(cursor_ff), .video_ff(video_ff), .xpos(xpos), .ypos(ypos),
    .acc(acc), .pixel(pixel)
  );

  rom_pc_model u_rom_pc_model (
    .pclk(pclk), .presetn(presetn), .pc_inc(pc_inc), .pc_load(pc_load),
    .pc_page(pc_page), .instr(instr), .pc(pc)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // monitors of write strobes and of the serial video line
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    we_q <= ram_we;
    if (ram_we === 1'b1 && we_q === 1'b0) wq.push_back(ram_wdata);
    if (uart_load === 1'b1) uq.push_back(uart_wdata);
    if (print_load === 1'b1) pq.push_back(print_data);
    pix <= {pix[34:0], pixel};
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task chk(input logic [31:0] e, input logic [31:0] s, input string nm);
    n_checks++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_pc(input logic [9:0] p);
    for (int i = 0; i < 3000 && pc !== p; i++) @(negedge pclk);
  endtask

  initial begin
    logic hit;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    ram_rdata = 8'h35;
    uart_rx_char = 8'hC3;
    cnd = '0;
    cnd.screen_top = 1'b1;
    for (int i = 0; i < 1024; i++) u_rom_pc_model.mem[i] = 8'h80;
    foreach (prog[i]) u_rom_pc_model.mem[prog[i][17:8]] = prog[i][7:0];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(32'h0, rd, "ctrl reset");
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'h0, rd, "stat reset");
    apb(1'b0, 8'h20, 32'h0);
    chk(32'h1, {31'h0, err}, "unmapped error");
    chk(32'h0, rd, "unmapped data");
    $display("test registers done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_pc(10'h021);
    chk(32'h0, {24'h0, xpos}, "x after steps");
    chk(32'h0, {24'h0, ypos}, "y after steps");
    chk(32'h35, {24'h0, acc}, "acc after steps");
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'h0F, rd, "stat mode one");
    apb(1'b0, ADDR_POS, 32'h0);
    chk(32'h00350000, rd, "pos");
    chk(32'h2, wq.size(), "ram writes");
    if (wq.size() == 2) begin
      chk(32'h35, {24'h0, wq[0]}, "acc to ram");
      chk(32'hC3, {24'h0, wq[1]}, "uart to ram");
    end
    chk(32'h1, uq.size(), "uart loads");
    $display("test program part one done");
    wait_pc(10'h106);
    repeat (60) @(negedge pclk);
    chk(32'h1, {31'h0, (pc === 10'h106) || (pc === 10'h107)}, "pc loop");
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'h10, rd, "stat final");
    chk(32'h1, pq.size(), "print loads");
    if (pq.size() == 1) chk(32'h35, {24'h0, pq[0]}, "print data");
    $display("test jumps done");
    apb(1'b1, ADDR_GADDR, 32'h1AD);
    apb(1'b1, ADDR_GDATA, 32'hA6);
    apb(1'b0, ADDR_GADDR, 32'h0);
    chk(32'h1AE, rd, "glyph addr step");
    apb(1'b1, ADDR_GADDR, 32'h1AD);
    apb(1'b0, ADDR_GDATA, 32'h0);
    chk(32'hA6, rd, "glyph data");
    repeat (40) @(posedge pclk);
    hit = 1'b0;
    // glyph bit 6 is the oldest sample of a seven bit run
    for (int i = 0; i < 30; i++) if (pix[i+:7] === 7'h26) hit = 1'b1;
    chk(32'h1, {31'h0, hit}, "pixel row");
    $display("test glyph done");
    stop_test();
  end
endmodule

// *** term_dec_pkg.sv ***
package term_dec_pkg;
  // time base: nine-slot ring, two rings per instruction cycle
  localparam logic [3:0] RING_LAST  = 4'h8;
  localparam logic [3:0] SLOT_A     = 4'h0;
  localparam logic [3:0] SLOT_B     = 4'h3;
  localparam logic [3:0] SLOT_C     = 4'h6;
  localparam logic [3:0] GLYPH_SLOT = 4'h2;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_POS   = 8'h08;
  localparam logic [7:0] ADDR_GADDR = 8'h0C;
  localparam logic [7:0] ADDR_GDATA = 8'h10;
  // field positions
  localparam int CTRL_RUN  = 0;
  localparam int ST_MODE   = 0;
  localparam int ST_CURSOR = 1;
  localparam int ST_VIDEO  = 2;
  localparam int ST_PRINT  = 3;
  localparam int ST_PAGE   = 4;
  localparam int ST_WE     = 6;
  // reset values and masks
  localparam logic       RUN_RST = 1'b0;
  localparam logic [7:0] IR_RST  = 8'h80;
  localparam logic [7:0] X3_MASK = 8'h08;
  // opcode groups, bits B C D with A clear
  localparam logic [2:0] GRP_POS  = 3'h0;
  localparam logic [2:0] GRP_CUR  = 3'h1;
  localparam logic [2:0] GRP_VID  = 3'h2;
  localparam logic [2:0] GRP_STEP = 3'h3;
  localparam logic [2:0] GRP_ACC  = 3'h4;
  localparam logic [2:0] GRP_SYS  = 3'h5;
  localparam logic [2:0] GRP_PRT  = 3'h6;
  localparam logic [2:0] GRP_MODE = 3'h7;

  typedef struct packed {
    logic line_60hz;
    logic printer_scan;
    logic uart_rx_ready;
    logic key_click;
    logic printer_request;
    logic uart_sending;
    logic video_scan;
    logic screen_top;
    logic key_typed;
  } cond_s;
endpackage

// *** terminal_microcode_decoder.sv ***
// Behaviour
// - group 000 H: mode 0 jump on 60 Hz line, mode 1 on acc not x
// - cursor group: E clears x,y; F decrements both; G acc from ram; H test
// - video group: E toggles x bit 3; F acc to ram; G acc up; H test
// - group 0100: zero clears cursor and video; E acc 0; F y down; G x<-ram
// - group 0100 H: mode 0 printer request, mode 1 acc equals ram
// - group 0101: zero loads print shifter; E mode 1; F page up; G uart to ram
// - group 0110: zero starts printer; E clears x; F x down; G ybuf<-ram
// - group 0110 H: mode 0 uart sending, mode 1 video scan flag
// - group 0111: zero halts printer and clears y; E mode 0; F acc down
// - group 0111 H: mode 0 not screen top, mode 1 no key typed
// - first phase runs the E-bit operations
// - second phase runs the F-bit operations, for the video group the G-bit step
// - third phase runs the all-zero EFGH operations
// - fourth phase clears the ram write flip-flop
// - fifth phase runs the G-bit data transfers
// - glyph rom of 1024 bytes, memory buffer gives address bits 9 to 3
// - glyph row chosen by accumulator bits 2 to 0
// - seven glyph bits load the pixel shifter every ring
// - pixel shifter sends glyph bit 6 first, bit 0 last
// - six phases from two passes of the nine-slot ring
// - jump met loads the next word, else counter skips it
// - page counter copied to counter bits 9 and 8 on a jump
module terminal_microcode_decoder
  import term_dec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  instr,
  input  wire logic [7:0]  ram_rdata,
  input  wire logic [7:0]  uart_rx_char,
  input  wire cond_s       cond_pins,
  output logic             pc_inc,
  output logic             pc_load,
  output logic      [1:0]  pc_page,
  output logic             ram_we,
  output logic      [7:0]  ram_wdata,
  output logic             uart_load,
  output logic      [7:0]  uart_wdata,
  output logic             print_load,
  output logic      [7:0]  print_data,
  output logic             printer_run,
  output logic             cursor_ff,
  output logic             video_ff,
  output logic      [7:0]  xpos,
  output logic      [7:0]  ypos,
  output logic      [7:0]  acc,
  output logic             pixel
);
  logic [3:0] slot_r;
  logic       half_r;
  logic       run_r;
  logic [7:0] ir_r;
  logic       mode_r;
  logic [1:0] page_r;
  logic [7:0] ybuf_r;
  logic [8:0] s1_r, s2_r, s3_r, cond_r;
  logic [6:0] mbuf_r;
  logic [7:0] glyph_q_r;
  logic [6:0] shift_r;
  logic [9:0] gaddr_r;
  logic [7:0] glyph_rom [1024];
  logic [7:0] x_nxt, y_nxt, a_nxt;
  logic       jcond;

  // input pins: three stages, accept once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi]   <= 1'b0;
          s2_r[gi]   <= 1'b0;
          s3_r[gi]   <= 1'b0;
          cond_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= cond_pins[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            cond_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate
  cond_s cs;
  assign cs = cond_r;

  // time base
  wire ring_end = (slot_r == RING_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= 4'h0;
      half_r <= 1'b0;
    end else begin
      slot_r <= ring_end ? 4'h0 : slot_r + 4'h1;
      if (ring_end) begin
        half_r <= ~half_r;
      end
    end
  end

  wire ph_one   = run_r & ~half_r & (slot_r == SLOT_A);
  wire ph_two   = run_r & ~half_r & (slot_r == SLOT_B);
  wire ph_three = run_r & ~half_r & (slot_r == SLOT_C);
  wire ph_four  = run_r &  half_r & (slot_r == SLOT_A);
  wire ph_five  = run_r &  half_r & (slot_r == SLOT_B);
  wire ph_six   = run_r &  half_r & (slot_r == SLOT_C);
  wire cyc_end  = half_r & ring_end;

  // decode: bit A clear marks an operation word
  wire       op_ok = ~ir_r[7];
  wire [2:0] grp   = ir_r[6:4];
  wire       zero  = (ir_r[3:0] == 4'h0);
  wire [7:0] do_e  = (ph_one & op_ok & ir_r[3]) ? 8'h01 << grp : 8'h00;
  wire [7:0] do_f  = (ph_two & op_ok & ir_r[2]) ? 8'h01 << grp : 8'h00;
  wire [7:0] do_z  = (ph_three & op_ok & zero) ? 8'h01 << grp : 8'h00;
  wire [7:0] do_g  = (ph_five & op_ok & ir_r[1]) ? 8'h01 << grp : 8'h00;
  // video group: accumulator step in the second phase, store in transfer phase
  wire       vid_inc = ph_two & op_ok & ir_r[1] & (grp == GRP_VID);
  wire       vid_st  = ph_five & op_ok & ir_r[2] & (grp == GRP_VID);
  wire       h_test  = ph_six & op_ok & ir_r[0];
  wire       jump_go = h_test & jcond;

  always_comb begin
    case (grp)
      GRP_POS:  jcond = mode_r ? (acc != xpos) : cs.line_60hz;
      GRP_CUR:  jcond = mode_r ? cs.uart_rx_ready : cs.printer_scan;
      GRP_VID:  jcond = mode_r ? (acc < ram_rdata) : cs.key_click;
      GRP_STEP: jcond = 1'b0;
      GRP_ACC:  jcond = mode_r ? (acc == ram_rdata) : cs.printer_request;
      GRP_SYS:  jcond = 1'b1;
      GRP_PRT:  jcond = mode_r ? cs.video_scan : cs.uart_sending;
      GRP_MODE: jcond = mode_r ? ~cs.key_typed : ~cs.screen_top;
      default:  jcond = 1'b0;
    endcase
  end

  // position and accumulator next values; phases never overlap
  always_comb begin
    x_nxt = xpos;
    if (do_e[GRP_CUR] | do_e[GRP_PRT]) x_nxt = 8'h00;
    if (do_e[GRP_POS] | do_e[GRP_STEP]) x_nxt = xpos + 8'h01;
    if (do_e[GRP_VID]) x_nxt = xpos ^ X3_MASK;
    if (do_f[GRP_CUR] | do_f[GRP_PRT]) x_nxt = xpos - 8'h01;
    if (do_g[GRP_ACC]) x_nxt = ram_rdata;
  end

  always_comb begin
    y_nxt = ypos;
    if (do_e[GRP_CUR]) y_nxt = 8'h00;
    if (do_e[GRP_STEP]) y_nxt = ypos - 8'h01;
    if (do_f[GRP_POS]) y_nxt = ypos + 8'h01;
    if (do_f[GRP_CUR] | do_f[GRP_ACC]) y_nxt = ypos - 8'h01;
    if (do_z[GRP_POS]) y_nxt = ybuf_r;
    if (do_z[GRP_MODE]) y_nxt = 8'h00;
  end

  always_comb begin
    a_nxt = acc;
    if (do_e[GRP_ACC]) a_nxt = 8'h00;
    if (do_f[GRP_STEP] | vid_inc) a_nxt = acc + 8'h01;
    if (do_f[GRP_MODE]) a_nxt = acc - 8'h01;
    if (do_g[GRP_CUR]) a_nxt = ram_rdata;
  end

  wire       ram_st  = do_g[GRP_POS] | vid_st | do_g[GRP_SYS];
  wire [7:0] st_data = do_g[GRP_POS] ? ybuf_r
                     : (vid_st ? acc : uart_rx_char);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r <= IR_RST;
      xpos <= 8'h00;
      ypos <= 8'h00;
      acc  <= 8'h00;
    end else begin
      if (cyc_end & run_r) ir_r <= instr;
      xpos <= x_nxt;
      ypos <= y_nxt;
      acc  <= a_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r      <= 1'b0;
      page_r      <= 2'h0;
      cursor_ff   <= 1'b0;
      video_ff    <= 1'b0;
      printer_run <= 1'b0;
      ybuf_r      <= 8'h00;
    end else begin
      if (do_e[GRP_SYS]) mode_r <= 1'b1;
      if (do_e[GRP_MODE]) mode_r <= 1'b0;
      if (do_f[GRP_SYS]) page_r <= page_r + 2'h1;
      if (do_z[GRP_CUR]) cursor_ff <= 1'b1;
      if (do_z[GRP_VID]) video_ff <= 1'b1;
      if (do_z[GRP_ACC]) begin
        cursor_ff <= 1'b0;
        video_ff  <= 1'b0;
      end
      if (do_z[GRP_PRT]) printer_run <= 1'b1;
      if (do_z[GRP_MODE]) printer_run <= 1'b0;
      if (do_g[GRP_PRT]) ybuf_r <= ram_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_we     <= 1'b0;
      ram_wdata  <= 8'h00;
      uart_load  <= 1'b0;
      uart_wdata <= 8'h00;
      print_load <= 1'b0;
      print_data <= 8'h00;
    end else begin
      if (ph_four) ram_we <= 1'b0;
      if (ram_st) begin
        ram_we    <= 1'b1;
        ram_wdata <= st_data;
      end
      uart_load <= do_g[GRP_STEP];
      if (do_g[GRP_STEP]) uart_wdata <= ram_rdata;
      print_load <= do_z[GRP_SYS];
      if (do_z[GRP_SYS]) print_data <= acc;
    end
  end

  // program counter requests: count at fifth phase, load or skip at sixth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_inc  <= 1'b0;
      pc_load <= 1'b0;
      pc_page <= 2'h0;
    end else begin
      pc_inc  <= ph_five | (h_test & ~jcond);
      pc_load <= jump_go;
      if (jump_go) pc_page <= page_r;
    end
  end

  // character path
  wire [9:0] glyph_addr = {mbuf_r, acc[2:0]};
  wire       glyph_ld   = (slot_r == GLYPH_SLOT);
  always_ff @(posedge pclk) begin
    glyph_q_r <= glyph_rom[glyph_addr];
    if (wr_gdata) glyph_rom[gaddr_r] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbuf_r  <= 7'h00;
      shift_r <= 7'h00;
    end else begin
      if (slot_r == SLOT_A) mbuf_r <= ram_rdata[6:0];
      if (glyph_ld) shift_r <= glyph_q_r[6:0];
      else shift_r <= {shift_r[5:0], 1'b0};
    end
  end
  assign pixel = shift_r[6];

  // apb slave: answer on the second access cycle
  wire        acc_ph   = psel & penable;
  wire        hit      = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT)
                       | (paddr == ADDR_POS) | (paddr == ADDR_GADDR)
                       | (paddr == ADDR_GDATA);
  wire        wr_fire  = acc_ph & pready & pwrite & hit;
  wire        wr_gdata = wr_fire & (paddr == ADDR_GDATA);
  wire [31:0] stat_v   = {25'h0, ram_we, page_r, printer_run,
                          video_ff, cursor_ff, mode_r};
  wire [31:0] rd_mux   =
      (paddr == ADDR_CTRL)  ? {31'h0, run_r} :
      (paddr == ADDR_STAT)  ? stat_v :
      (paddr == ADDR_POS)   ? {ybuf_r, acc, ypos, xpos} :
      (paddr == ADDR_GADDR) ? {22'h0, gaddr_r} :
      (paddr == ADDR_GDATA) ? {24'h0, glyph_rom[gaddr_r]} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (acc_ph & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= pwrite ? 32'h0 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r   <= RUN_RST;
      gaddr_r <= 10'h000;
    end else begin
      if (wr_fire & (paddr == ADDR_CTRL)) run_r <= pwdata[CTRL_RUN];
      if (wr_fire & (paddr == ADDR_GADDR)) gaddr_r <= pwdata[9:0];
      if (wr_gdata) gaddr_r <= gaddr_r + 10'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire run_cyc = ph_one & op_ok;
  property p_jump_eq;
    h_test & (grp == GRP_ACC) & mode_r & (acc == ram_rdata) |=> pc_load;
  endproperty
  a_jump_eq: assert property (p_jump_eq) else $error("no jump on acc=ram");
  property p_noop;
    ph_six & op_ok & ~ir_r[0] |=> !pc_load && !pc_inc;
  endproperty
  a_noop: assert property (p_noop) else $error("pc moved on no-op");
  property p_clear_both;
    run_cyc & ir_r[3] & (grp == GRP_CUR) |=> xpos == 8'h00 && ypos == 8'h00;
  endproperty
  a_clear_both: assert property (p_clear_both) else $error("x/y not clear");
  property p_toggle;
    run_cyc & ir_r[3] & (grp == GRP_VID) |=> xpos == ($past(xpos) ^ X3_MASK);
  endproperty
  a_toggle: assert property (p_toggle) else $error("x bit 3 not toggled");
  property p_we_clear;
    ph_four & ~ram_st |=> !ram_we;
  endproperty
  a_we_clear: assert property (p_we_clear) else $error("write ff not cleared");
  property p_page;
    jump_go |=> pc_page == $past(page_r);
  endproperty
  a_page: assert property (p_page) else $error("page not copied");
  property p_shift;
    glyph_ld |=> ##1 pixel == $past(glyph_q_r[5], 2);
  endproperty
  a_shift: assert property (p_shift) else $error("pixel order wrong");
  property p_ring;
    ph_one |-> ##18 (ph_one || !run_r);
  endproperty
  a_ring: assert property (p_ring) else $error("cycle not 18 clocks");
  property p_print;
    ph_three & op_ok & zero & (grp == GRP_PRT) |=> printer_run;
  endproperty
  a_print: assert property (p_print) else $error("printer not started");

  c_jump: cover property (jump_go);
  c_skip: cover property (h_test & ~jcond);
  c_glyph: cover property (glyph_ld & (glyph_q_r != 8'h00));
  c_apb_wr: cover property (wr_fire);
endmodule
